// File: src/apmc_params.svh
// constants for the amplitude / phase measurement compare block
// assumes inclusion by bare name from design and bench files
`ifndef APMC_PARAMS_SVH
`define APMC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (word indices, byte addr = 4*idx)
// ----------------------------------------------------------------
`define APMC_IDX_AM_CFG      8'h32
`define APMC_IDX_AM_REFV     8'h33
`define APMC_IDX_AM_AVG      8'h34
`define APMC_IDX_AM_RES      8'h35
`define APMC_IDX_PM_CFG      8'h36
`define APMC_IDX_PM_REFV     8'h37
`define APMC_IDX_PM_AVG      8'h38
`define APMC_IDX_PM_RES      8'h39
`define APMC_IDX_WAKE_CTRL   8'h31
`define APMC_IDX_IRQ_STATUS  8'h40
`define APMC_IDX_IRQ_ENABLE  8'h41
`define APMC_IDX_IRQ_CLEAR   8'h42
`define APMC_IDX_CMD         8'h43

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define APMC_THR_MSB         7
`define APMC_THR_LSB         4
`define APMC_INCL_BIT        3
`define APMC_WGT_MSB         2
`define APMC_WGT_LSB         1
`define APMC_USE_AVG_BIT     0
`define APMC_WAKE_AM_BIT     2
`define APMC_WAKE_PM_BIT     1
`define APMC_IRQ_AM_BIT      0
`define APMC_IRQ_PM_BIT      1
`define APMC_CMD_DEFAULT_BIT 0

// ----------------------------------------------------------------
// reset values and weight shifts (4, 8, 16, 32)
// ----------------------------------------------------------------
`define APMC_RST_BYTE        8'h00
`define APMC_SHIFT_BASE      3'h2
`define APMC_BAD_READ        32'hdeadbeef

`endif

// File: src/apmc_pkg.sv
// types shared by the compare block and its channel engine
// assumes the params header sits alongside
package apmc_pkg;
  // one channel's decoded configuration
  typedef struct packed {
    logic [3:0] thr;      // delta limit
    logic       incl;     // include interrupting sample
    logic [1:0] wgt;      // weight code
    logic       use_avg;  // average as reference
  } apmc_cfg_t;

  // one measurement strobe with its value
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } apmc_meas_t;

  // bus answer state
  typedef enum logic [0:0] {APMC_IDLE, APMC_ANSWER} apmc_bus_state_t;
endpackage

// File: src/apmc_channel.sv
// one measurement channel: compare against reference, auto-average
// assumes a synchronous measurement strobe and a defaults pulse
`timescale 1ns/1ps
`default_nettype none
`include "apmc_params.svh"
module apmc_channel (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // control
  input  wire logic               set_default,
  input  wire apmc_pkg::apmc_cfg_t cfg,
  input  wire logic [7:0]         ref_reg,
  input  wire apmc_pkg::apmc_meas_t meas,
  // results
  output logic [7:0]              average,
  output logic [7:0]              result,
  output logic                    event_hit
);
  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  wire logic [7:0] ref_sel = cfg.use_avg ? average : ref_reg;
  wire logic [7:0] diff    = (meas.value >= ref_sel) ? meas.value - ref_sel
                                                     : ref_sel - meas.value;
  wire logic       over    = diff > {4'h0, cfg.thr};
  // interrupting sample joins the average only when asked
  wire logic       incl    = !over || cfg.incl;
  // signed step, shifted by 2..5 (weights 4..32), arithmetic shift
  wire logic [2:0] shamt   = `APMC_SHIFT_BASE + {1'b0, cfg.wgt};
  wire logic signed [8:0] step = $signed({1'b0, meas.value}) - $signed({1'b0, average});
  wire logic signed [8:0] adj  = step >>> shamt;
  wire logic [8:0] sum     = {1'b0, average} + adj;
  wire logic [7:0] next_average = sum[7:0];

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      average   <= `APMC_RST_BYTE;
      result    <= `APMC_RST_BYTE;
      event_hit <= 1'b0;
    end else if (set_default) begin
      average   <= `APMC_RST_BYTE;
      result    <= `APMC_RST_BYTE;
      event_hit <= 1'b0;
    end else begin
      event_hit <= meas.valid && over;
      if (meas.valid) begin
        result <= meas.value;
        if (incl) begin
          average <= next_average;
        end
      end
    end
  end
endmodule // apmc_channel
`default_nettype wire

// File: src/apmc_irq.sv
// sticky interrupt status with enable mask and write-one clear
// assumes one-cycle event pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module apmc_irq #(
  parameter int N = 2
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // events and software
  input  wire logic [N-1:0] evt,
  input  wire logic [N-1:0] clr,
  input  wire logic [N-1:0] enable,
  input  wire logic         set_default,
  // outputs
  output logic [N-1:0]      status,
  output logic              irq
);
  // ----------------------------------------------------------------
  // per-bit sticky flags, set beats clear
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        status[i] <= 1'b0;
      end else if (evt[i]) begin
        status[i] <= 1'b1;
      end else if (clr[i] || set_default) begin
        status[i] <= 1'b0;
      end
    end
  end
  // level output from a flop; rises with status through the event path, falls one cycle after status
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status | evt) & enable);
    end
  end
endmodule // apmc_irq
`default_nettype wire

// File: src/amp_phase_measure_compare.sv
// top of the amplitude / phase measurement compare block
// assumes Avalon-MM master on the same clock; measurement strobes synchronous
`timescale 1ns/1ps
`default_nettype none
`include "apmc_params.svh"
// How it works
// - amplitude threshold is config bits 7:4
// - phase threshold is config bits 7:4
// - amplitude bit 3 includes interrupting sample
// - phase bit 3 includes interrupting sample
// - bits 2:1 pick weight 4/8/16/32
// - amplitude bit 0 selects average reference
// - phase bit 0 selects average reference
// - config/reference registers RW, reset zero
// - display registers clear on reset/defaults
// - wake bit 2 enables amplitude measurement
// - wake bit 1 enables phase measurement
module amp_phase_measure_compare (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // measurement front end
  input  wire logic        timer_timeout,
  input  wire logic [7:0]  amplitude_value,
  input  wire logic [7:0]  phase_value,
  input  wire logic        amplitude_value_valid,
  input  wire logic        phase_value_valid,
  output logic             amplitude_measure_start,
  output logic             phase_measure_start,
  // interrupt
  output logic             irq
);
  // ----------------------------------------------------------------
  // timing at a glance
  // ----------------------------------------------------------------
  // bus: a request seen while idle is answered on the next edge with
  //   waitrequest low and read data registered, so every access costs
  //   two cycles; a write lands on the edge that sees waitrequest low
  // sample: a valid pulse updates result and average on the next edge;
  //   the status bit and the irq flop follow one edge later, the irq
  //   through the event path so it never waits for the status flop
  // defaults: the command raises set_default for one cycle, which then
  //   clears every register and display, and each status bit without an event that cycle, on the next edge
  // limitation: a sample that arrives while set_default is high is lost,
  //   the price of one shared clear pulse instead of per-register logic
  // limitation: only byte lane 0 carries data; a write with that lane
  //   off is dropped, so software must not rely on wider writes
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // the four software registers hold exactly what software wrote;
  // only the channel engines decode their fields
  logic [7:0] am_cfg, am_refv, pm_cfg, pm_refv; // software registers
  logic [7:0] wake_ctrl;                         // wake-up control
  logic [1:0] irq_enable;                        // interrupt mask
  logic       set_default;                       // restore-defaults pulse
  apmc_pkg::apmc_bus_state_t bus_state;          // answer phase
  wire logic [7:0] am_avg, am_res, pm_avg, pm_res;
  wire logic [1:0] irq_status;
  wire logic am_hit, pm_hit, irq_w;

  // ----------------------------------------------------------------
  // bus decode: one wait state, answered in APMC_ANSWER
  // ----------------------------------------------------------------
  wire logic [7:0] idx  = avs_address[9:2];
  wire logic       req  = avs_read || avs_write;
  wire logic       take = req && bus_state == apmc_pkg::APMC_ANSWER;
  wire logic       wr   = take && avs_write && avs_byteenable[0];
  wire logic [7:0] wd   = avs_writedata[7:0];
  // one write strobe per writable register; other indices fall away
  wire logic wr_am_cfg = wr && idx == `APMC_IDX_AM_CFG;
  wire logic wr_am_refv = wr && idx == `APMC_IDX_AM_REFV;
  wire logic wr_pm_cfg = wr && idx == `APMC_IDX_PM_CFG;
  wire logic wr_pm_refv = wr && idx == `APMC_IDX_PM_REFV;
  wire logic wr_wake   = wr && idx == `APMC_IDX_WAKE_CTRL;
  wire logic wr_en     = wr && idx == `APMC_IDX_IRQ_ENABLE;
  wire logic wr_clr    = wr && idx == `APMC_IDX_IRQ_CLEAR;
  wire logic wr_cmd    = wr && idx == `APMC_IDX_CMD && wd[`APMC_CMD_DEFAULT_BIT];
  wire logic [1:0] clr_bits = wr_clr ? wd[1:0] : 2'h0;

  // read mux; unmapped answers a marker value
  logic [31:0] rd_sel;
  always_comb begin
    if (idx == `APMC_IDX_AM_CFG) rd_sel = {24'h0, am_cfg};
    else if (idx == `APMC_IDX_AM_REFV) rd_sel = {24'h0, am_refv};
    else if (idx == `APMC_IDX_AM_AVG) rd_sel = {24'h0, am_avg};
    else if (idx == `APMC_IDX_AM_RES) rd_sel = {24'h0, am_res};
    else if (idx == `APMC_IDX_PM_CFG) rd_sel = {24'h0, pm_cfg};
    else if (idx == `APMC_IDX_PM_REFV) rd_sel = {24'h0, pm_refv};
    else if (idx == `APMC_IDX_PM_AVG) rd_sel = {24'h0, pm_avg};
    else if (idx == `APMC_IDX_PM_RES) rd_sel = {24'h0, pm_res};
    else if (idx == `APMC_IDX_WAKE_CTRL) rd_sel = {24'h0, wake_ctrl};
    else if (idx == `APMC_IDX_IRQ_STATUS) rd_sel = {30'h0, irq_status};
    else if (idx == `APMC_IDX_IRQ_ENABLE) rd_sel = {30'h0, irq_enable};
    else if (idx == `APMC_IDX_IRQ_CLEAR) rd_sel = 32'h0;
    else if (idx == `APMC_IDX_CMD) rd_sel = 32'h0;
    else rd_sel = `APMC_BAD_READ;
  end

  // ----------------------------------------------------------------
  // bus handshake: waitrequest high at first cycle, low on second
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_state       <= apmc_pkg::APMC_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if (req && bus_state == apmc_pkg::APMC_IDLE) begin
      bus_state       <= apmc_pkg::APMC_ANSWER;
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rd_sel;
    end else begin
      bus_state       <= apmc_pkg::APMC_IDLE;
      avs_waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // software registers, cleared by reset and defaults command
  // ----------------------------------------------------------------
  // set_default is a registered one-cycle pulse; it clears on the edge
  // after the command write, so a write in that cycle is discarded
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // power-up: every setting zero
      am_cfg      <= `APMC_RST_BYTE;
      am_refv     <= `APMC_RST_BYTE;
      pm_cfg      <= `APMC_RST_BYTE;
      pm_refv     <= `APMC_RST_BYTE;
      wake_ctrl   <= `APMC_RST_BYTE;
      irq_enable  <= 2'h0;
      set_default <= 1'b0;
    end else if (set_default) begin
      // restore-defaults: same values as power-up, pulse drops
      am_cfg      <= `APMC_RST_BYTE;
      am_refv     <= `APMC_RST_BYTE;
      pm_cfg      <= `APMC_RST_BYTE;
      pm_refv     <= `APMC_RST_BYTE;
      wake_ctrl   <= `APMC_RST_BYTE;
      irq_enable  <= 2'h0;
      set_default <= 1'b0;
    end else begin
      // pulse only from a command write with bit 0 set
      set_default <= wr_cmd;
      // plain byte writes, one register per strobe
      if (wr_am_cfg) am_cfg <= wd;
      if (wr_am_refv) am_refv <= wd;
      if (wr_pm_cfg) pm_cfg <= wd;
      if (wr_pm_refv) pm_refv <= wd;
      if (wr_wake) wake_ctrl <= wd;
      if (wr_en) irq_enable <= wd[1:0];
    end
  end

  // ----------------------------------------------------------------
  // measurement starts on timer timeout
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      amplitude_measure_start <= 1'b0;
      phase_measure_start     <= 1'b0;
    end else begin
      amplitude_measure_start <= timer_timeout && wake_ctrl[`APMC_WAKE_AM_BIT];
      phase_measure_start     <= timer_timeout && wake_ctrl[`APMC_WAKE_PM_BIT];
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  wire apmc_pkg::apmc_cfg_t am_c = am_cfg;
  wire apmc_pkg::apmc_cfg_t pm_c = pm_cfg;
  wire apmc_pkg::apmc_meas_t am_m = {amplitude_value_valid, amplitude_value};
  wire apmc_pkg::apmc_meas_t pm_m = {phase_value_valid, phase_value};

  apmc_channel u_am (
    .clock       (clock),
    .rst_n       (rst_n),
    .set_default (set_default),
    .cfg         (am_c),
    .ref_reg     (am_refv),
    .meas        (am_m),
    .average     (am_avg),
    .result      (am_res),
    .event_hit   (am_hit)
  );

  apmc_channel u_pm (
    .clock       (clock),
    .rst_n       (rst_n),
    .set_default (set_default),
    .cfg         (pm_c),
    .ref_reg     (pm_refv),
    .meas        (pm_m),
    .average     (pm_avg),
    .result      (pm_res),
    .event_hit   (pm_hit)
  );

  apmc_irq #(.N(2)) u_irq (
    .clock       (clock),
    .rst_n       (rst_n),
    .evt         ({pm_hit, am_hit}),
    .clr         (clr_bits),
    .enable      (irq_enable),
    .set_default (set_default),
    .status      (irq_status),
    .irq         (irq_w)
  );
  assign irq = irq_w;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // distance of each incoming sample from its fixed reference register;
  // these properties judge the fixed-reference case only, the average
  // reference is left to the bench model
  wire logic [7:0] am_dist = (amplitude_value > am_refv) ? amplitude_value - am_refv
                                                         : am_refv - amplitude_value;
  wire logic [7:0] pm_dist = (phase_value > pm_refv) ? phase_value - pm_refv
                                                     : pm_refv - phase_value;

  // amplitude beyond the limit must flag an event on the next edge
  AST_AM_THR: assert property (
      amplitude_value_valid && !set_default && !am_cfg[0] && am_dist > {4'h0, am_cfg[7:4]}
      |=> am_hit) else $error("amplitude over limit missed");
  // amplitude at or inside the limit must stay quiet
  AST_AM_WITHIN: assert property (
      amplitude_value_valid && !set_default && !am_cfg[0] && am_dist <= {4'h0, am_cfg[7:4]}
      |=> !am_hit) else $error("amplitude hit within limit");
  // phase beyond the limit must flag an event on the next edge
  AST_PM_OVER: assert property (
      phase_value_valid && !set_default && !pm_cfg[0] && pm_dist > {4'h0, pm_cfg[7:4]}
      |=> pm_hit) else $error("phase over limit missed");
  // phase at or inside the limit must stay quiet
  AST_PM_THR: assert property (
      phase_value_valid && !set_default && !pm_cfg[0] && pm_dist <= {4'h0, pm_cfg[7:4]}
      |=> !pm_hit) else $error("phase hit within limit");
  // an excluded interrupting amplitude sample leaves the average alone
  AST_AM_EXCL: assert property (
      am_hit && !am_cfg[3] && !$past(set_default) |-> am_avg == $past(am_avg))
      else $error("excluded amplitude averaged");
  // an excluded interrupting phase sample leaves the average alone
  AST_PM_EXCL: assert property (
      pm_hit && !pm_cfg[3] && !$past(set_default) |-> pm_avg == $past(pm_avg))
      else $error("excluded phase averaged");
  // the raw amplitude sample is shown one edge later
  AST_AM_RES: assert property (
      amplitude_value_valid && !set_default |=> am_res == $past(amplitude_value))
      else $error("amplitude result not shown");
  // the raw phase sample is shown one edge later
  AST_PM_RES: assert property (
      phase_value_valid && !set_default |=> pm_res == $past(phase_value))
      else $error("phase result not shown");
  // restore-defaults zeroes am_cfg, pm_refv, am_avg and pm_res
  AST_DEF_CLR: assert property (
      set_default |=> am_cfg == 8'h00 && pm_refv == 8'h00 && am_avg == 8'h00 && pm_res == 8'h00)
      else $error("defaults not restored");
  // restore-defaults zeroes the remaining displays
  AST_DISP_CLR: assert property (
      set_default |=> am_res == 8'h00 && pm_avg == 8'h00)
      else $error("display not cleared");
  // an enabled amplitude wake starts a measurement
  AST_WAKE_AM: assert property (
      timer_timeout && wake_ctrl[2] && !set_default |=> amplitude_measure_start)
      else $error("amplitude start missing");
  // no phase start without its wake bit
  AST_WAKE_PM: assert property (
      !wake_ctrl[1] |=> !phase_measure_start)
      else $error("phase start without enable");
  // an enabled phase wake starts a measurement
  AST_WAKE_PM_ON: assert property (
      timer_timeout && wake_ctrl[1] && !set_default |=> phase_measure_start)
      else $error("phase start missing");
  // an enabled amplitude event raises the interrupt on the next edge
  AST_IRQ: assert property (
      am_hit && irq_enable[0] |=> irq)
      else $error("irq missing");
  // the answer lasts exactly one cycle
  AST_WAIT: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low twice");

  // main scenarios worth seeing at least once
  COV_AM_HIT: cover property (am_hit);
  COV_PM_AVG: cover property (phase_value_valid && pm_cfg[0]);
  COV_IRQ: cover property (irq ##1 !irq);
  COV_DEF: cover property (set_default);
  COV_AM_EXCL: cover property (am_hit && !am_cfg[3]);
endmodule // amp_phase_measure_compare
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the amplitude / phase compare block
// assumes the design sources under src/ and the params header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "apmc_params.svh"
module testbench;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic        clock, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [9:0]  avs_address;        // byte address, index in bits 9:2
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [3:0]  avs_byteenable;
  logic        timer_timeout, amplitude_value_valid, phase_value_valid;
  logic [7:0]  amplitude_value, phase_value;
  logic        amplitude_measure_start, phase_measure_start, irq;
  int          err_total, n_compared, seed;
  int          m_avg[2], m_res[2], m_st, m_en;  // behavioural model
  logic [7:0]  i_cfg[2] = '{`APMC_IDX_AM_CFG, `APMC_IDX_PM_CFG};
  logic [7:0]  i_ref[2] = '{`APMC_IDX_AM_REFV, `APMC_IDX_PM_REFV};
  logic [7:0]  i_avg[2] = '{`APMC_IDX_AM_AVG, `APMC_IDX_PM_AVG};
  logic [7:0]  i_res[2] = '{`APMC_IDX_AM_RES, `APMC_IDX_PM_RES};
  logic [7:0]  i_all[11] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38,
                             8'h39, 8'h40, 8'h41};
  logic [7:0]  i_rw[6] = '{8'h31, 8'h32, 8'h33, 8'h36, 8'h37, 8'h41};

  amp_phase_measure_compare uut (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_timeout(timer_timeout), .amplitude_value(amplitude_value),
    .phase_value(phase_value), .amplitude_value_valid(amplitude_value_valid),
    .phase_value_valid(phase_value_valid),
    .amplitude_measure_start(amplitude_measure_start),
    .phase_measure_start(phase_measure_start), .irq(irq));

  // 25 MHz clock
  always #20 clock = ~clock;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // one comparison, mismatch reported at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    avs_address    <= {idx, 2'b00};
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    @(posedge clock);
    // only the watchdog limits a wait for the answer
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so the strobe is never driven twice in a time step
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, 4'hf, x);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, 4'hf, x);
    check(x, exp);
  endtask

  // timer timeout pulse; the start pulses follow one cycle later
  task automatic tick(input logic ea, input logic ep);
    timer_timeout <= 1'b1;
    @(posedge clock);
    timer_timeout <= 1'b0;
    #1 check({31'h0, amplitude_measure_start}, {31'h0, ea});
    check({31'h0, phase_measure_start}, {31'h0, ep});
    @(posedge clock);
  endtask

  // one measurement on a channel with the model stepped alongside
  task automatic meas(input int ch, input logic [7:0] cfg, input int refv, input int v);
    int r;
    int d;
    logic hit;
    r   = cfg[0] ? m_avg[ch] : refv;
    d   = v - r;
    hit = ((d < 0) ? -d : d) > cfg[7:4];
    if (!hit || cfg[3])
      m_avg[ch] = (m_avg[ch] + ((v - m_avg[ch]) >>> (cfg[2:1] + 2))) & 8'hff;
    m_res[ch] = v;
    if (hit)
      m_st = m_st | (1 << ch);
    tick(1'b1, 1'b1);
    amplitude_value       <= (ch == 0) ? v[7:0] : 8'($random(seed));
    phase_value           <= (ch == 1) ? v[7:0] : 8'($random(seed));
    amplitude_value_valid <= (ch == 0);
    phase_value_valid     <= (ch == 1);
    @(posedge clock);
    amplitude_value_valid <= 1'b0;
    phase_value_valid     <= 1'b0;
    repeat (3) @(posedge clock);
    rd_chk(i_avg[ch], m_avg[ch]);
    rd_chk(i_res[ch], m_res[ch]);
    rd_chk(`APMC_IDX_IRQ_STATUS, m_st);
    check({31'h0, irq}, {31'h0, (m_st & m_en) != 0});
  endtask

  // verdict in one place
  task automatic complete_run;
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: the whole run needs just over a thousand cycles
  // ----------------------------------------------------------------
  initial begin
    #(40 * 20000);
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] cfg;
    int         refv, v, ch;
    clock = 1'b0; rst_n = 1'b0; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = '0; avs_byteenable = 4'hf; timer_timeout = 1'b0;
    amplitude_value = '0; phase_value = '0; amplitude_value_valid = 1'b0;
    phase_value_valid = 1'b0; err_total = 0; n_compared = 0; seed = 32'hbc56;
    m_avg = '{0, 0}; m_res = '{0, 0}; m_st = 0; m_en = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    // every readable register starts at zero
    foreach (i_all[k]) rd_chk(i_all[k], 32'h0);
    rd_chk(8'h50, `APMC_BAD_READ);
    // read-write registers keep their low byte only, irq enable its bits 1:0
    foreach (i_rw[k]) begin
      v = $random(seed);
      wr(i_rw[k], v);
      rd_chk(i_rw[k], v & ((i_rw[k] == `APMC_IDX_IRQ_ENABLE) ? 32'h3 : 32'hff));
    end
    // display writes and byte-lane-off writes must be ignored
    wr(`APMC_IDX_AM_AVG, 32'h5a);
    rd_chk(`APMC_IDX_AM_AVG, 32'h0);
    wr(`APMC_IDX_AM_REFV, 32'h3c);
    bus(1'b1, `APMC_IDX_AM_REFV, 32'h5a, 4'he, rdv);
    rd_chk(`APMC_IDX_AM_REFV, 32'h3c);
    // timeout gated by the wake bits, one channel at a time
    wr(`APMC_IDX_WAKE_CTRL, 32'h00);
    tick(1'b0, 1'b0);
    wr(`APMC_IDX_WAKE_CTRL, 32'h04);
    tick(1'b1, 1'b0);
    wr(`APMC_IDX_WAKE_CTRL, 32'h02);
    tick(1'b0, 1'b1);
    wr(`APMC_IDX_WAKE_CTRL, 32'h06);
    // sweep weights, include flag, reference source and the threshold edge
    for (int i = 0; i < 32; i++) begin
      ch   = i & 1;
      cfg  = {4'($random(seed)), 1'($random(seed)), 2'((i >> 1) & 3), 1'($random(seed))};
      refv = $random(seed) & 8'hff;
      m_en = $random(seed) & 3;
      wr(i_cfg[ch], cfg);
      wr(i_ref[ch], refv);
      wr(`APMC_IDX_IRQ_ENABLE, m_en);
      v = (cfg[0] ? m_avg[ch] : refv) + ($random(seed) % (int'(cfg[7:4]) + 3));
      v = (v < 0) ? 0 : ((v > 255) ? 255 : v);
      meas(ch, cfg, refv, v);
      wr(`APMC_IDX_IRQ_CLEAR, 32'h3);
      m_st = 0;
      rd_chk(`APMC_IDX_IRQ_STATUS, 32'h0);
      check({31'h0, irq}, 32'h0);
    end
    // restore-defaults clears settings and displays alike
    wr(`APMC_IDX_CMD, 32'h1);
    repeat (2) @(posedge clock);
    foreach (i_all[k]) rd_chk(i_all[k], 32'h0);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
